// >>> sitsig_pkg.sv
`default_nettype none
package sitsig_pkg;
  // register offsets on the serial control port
  localparam logic [7:0] ADDR_MODE = 8'hC1;
  localparam logic [7:0] ADDR_AUDIO = 8'hC2;
  localparam logic [7:0] ADDR_TXTONE = 8'hC3;
  localparam logic [7:0] ADDR_IRQST = 8'hC6;
  localparam logic [7:0] ADDR_PROG = 8'hC8;
  localparam logic [7:0] ADDR_TSTAT = 8'hCC;
  // mode control fields
  localparam int MODE_CTCSS_BIT = 0;
  localparam int MODE_DCS_BIT = 1;
  localparam int MODE_HPF_BIT = 3;
  localparam int MODE_AUDIO_BIT = 4;
  localparam int MODE_DATA_BIT = 5;
  localparam int MODE_INB_LSB = 9;
  localparam int MODE_DUAL_BIT = 12;
  localparam int MODE_IRQEN_BIT = 15;
  localparam logic [2:0] INB_RX = 3'h1;
  localparam logic [2:0] INB_TX = 3'h2;
  localparam logic [15:0] PATH_MASK = 16'h0030;
  localparam logic [15:0] SUB_MASK = 16'h000B;
  // audio control fields and selection values
  localparam int AUD_PH_LSB = 8;
  localparam logic [7:0] SEL_USER = 8'h54;
  localparam logic [7:0] SEL_USER_INV = 8'hB8;
  localparam logic [7:0] SEL_TURNOFF = 8'hFE;
  localparam logic [15:0] PH_120 = 16'h5555;
  localparam logic [15:0] PH_180 = 16'h8000;
  localparam logic [15:0] PH_240 = 16'hAAAB;
  // status fields and tone codes
  localparam int IRQ_DUAL_BIT = 12;
  localparam int IRQ_INB_BIT = 13;
  localparam int TS_DUAL_BIT = 10;
  localparam int TC_GROUP_BIT = 15;
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_UNREC = 5'h0F;
  localparam logic [3:0] CODE_REPEAT = 4'hE;
  // programming locations: bit 5 picks block 2
  localparam logic [5:0] LOC_TONE_LEVEL_SETTING = 6'h00;
  localparam logic [5:0] LOC_SELCALL_FIRST = 6'h02;
  localparam logic [5:0] LOC_SELCALL_LAST = 6'h11;
  localparam logic [5:0] LOC_CUSTOM_TONE_ONE_FREQ = 6'h12;
  localparam logic [5:0] LOC_CUSTOM_LAST = 6'h15;
  localparam logic [5:0] LOC_SQUELCH_CODE_CONFIG_WORD = 6'h21;
  localparam logic [5:0] LOC_DCS_LO = 6'h22;
  localparam logic [5:0] LOC_DCS_HI = 6'h23;
  localparam int SQ_LEN24_BIT = 11;
  localparam int DCS_LEN23 = 23;
  localparam int DCS_LEN24 = 24;
  // default selective-calling set, tone 0 in the low slice
  localparam logic [15:0][11:0] EEA_TONES = {12'h960, 12'h83E, 12'h3DF, 12'h8C7,
    12'h3A2, 12'h41F, 12'h744, 12'h6D3, 12'h668, 12'h604, 12'h5A6, 12'h54E,
    12'h4FB, 12'h4AD, 12'h464, 12'h7BD};
  localparam logic [11:0] MATCH_TOL_HZ = 12'h014;
  localparam logic [11:0] INB_MIN_HZ = 12'h120;
  localparam logic [11:0] INB_MAX_HZ = 12'hBB8;
  localparam logic [11:0] INB_LOW_HZ = 12'h190;
  localparam int CT_BASE_DHZ = 670;
  localparam int CT_STEP_DHZ = 10;
  // timing
  localparam longint CLK_HZ = 100_000_000;
  localparam int SAMPLE_HZ = 8000;
  localparam int SAMPLE_CYCLES = int'(CLK_HZ / SAMPLE_HZ);
  localparam longint DCS_RATE_CBPS = 13440;
  localparam int DCS_BIT_CYCLES = int'((CLK_HZ * 100 + DCS_RATE_CBPS / 2) / DCS_RATE_CBPS);
  localparam int PH_SHIFT_MS = 20;
  localparam int SHIFT_SAMPLES = SAMPLE_HZ * PH_SHIFT_MS / 1000;
  localparam logic [15:0] PH_STEP = 16'((32768 + SHIFT_SAMPLES - 1) / SHIFT_SAMPLES);
  localparam int PH_MUL_HZ = (65536 * 1024 + SAMPLE_HZ / 2) / SAMPLE_HZ;
  localparam int PH_MUL_DHZ = (65536 * 1024 + SAMPLE_HZ * 5) / (SAMPLE_HZ * 10);
  localparam int DCS_OFF_MIN_MS = 150;
  localparam int DCS_OFF_MAX_MS = 200;
  localparam int DCS_OFF_CYCLES = int'(CLK_HZ / 1000 * (DCS_OFF_MIN_MS + DCS_OFF_MAX_MS) / 2);
  // state encodings
  typedef enum logic [1:0] {SC_IDLE = 2'b01, SC_RUN = 2'b10} sitsig_scan_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_W2 = 4'b0010, H_READ = 4'b0100, H_HOLD = 4'b1000
  } sitsig_hst_t;
endpackage
`default_nettype wire

// >>> sitsig_if.sv
`default_nettype none
interface sitsig_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [5:0] loc;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic irq;
  modport dev (input wr, rd, addr, loc, wdata, output rdata, rvalid, irq);
  modport host (output wr, rd, addr, loc, wdata, input rdata, rvalid, irq);
endinterface
`default_nettype wire

// >>> sitsig_dev.sv
`default_nettype none
// Summary of operation
// - sub-audio tone picked by audio bits 7-0
// - phase field b9-8 gives 120/180/240 degrees
// - phase retarded gradually, 180 within 20 ms
// - 23/24-bit squelch word, one shared pattern
// - word sent NRZ at 134.4 bits per second
// - word sent least significant bit first
// - true or inverted polarity by code setting
// - config word bit 11 selects 24-bit length
// - host ends code with 254 for 150-200 ms
// - host keeps custom tones 288-3000 Hz, low-tone rules
// - default tone set loaded, host may overwrite
// - host inserts repeat tone 14 for a repeated group tone
// - inband mode from mode bits 11-9
// - interrupt on valid tone state change
// - first matching table entry reported, b13 set
// - four custom tone frequencies from programming
// - code: b15 group, b14-11 tone number
// - dual-tone detect allowed alongside inband modes
// - dual tone sets b10, b12, overwrites value
// - tone from tx tone register at set level
// - host mutes audio and data during tones, except in the low-tone mode write
// - selection 84 user word, 184 inverted
module sitsig_dev
  import sitsig_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES,
  parameter int DCS_BIT_CYC = DCS_BIT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port toward the host
  sitsig_if.dev bus,
  // receive detector results
  input wire logic det_strobe,
  input wire logic det_on,
  input wire logic [11:0] det_freq,
  input wire logic dual_strobe,
  input wire logic [3:0] dual_code,
  // generated signalling
  output logic [7:0] sub_phase,
  output logic sub_on,
  output logic dcs_bit,
  output logic dcs_on,
  output logic tone_sq,
  output logic tone_on,
  output logic [11:0] tone_level
);
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] audio;
    logic [15:0] txtone;
    logic [15:0] irqst;
    logic [15:0] tstat;
    logic [11:0] level;
    logic [19:0][11:0] tbl;
    logic [23:0] dcs_word;
    logic dcs24;
    logic [13:0] smp_cnt;
    logic [19:0] bit_cnt;
    logic [15:0] sub_acc;
    logic [15:0] shift;
    logic [15:0] tone_acc;
    logic [4:0] dcs_pos;
    sitsig_scan_t sc;
    logic [4:0] scan;
    logic [11:0] freq;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;
    logic [7:0] sub_phase;
    logic sub_on;
    logic dcs_bit;
    logic dcs_on;
    logic tone_sq;
    logic tone_on;
    logic [11:0] tone_level;
  } sitsig_dev_st_t;

  sitsig_dev_st_t r;
  sitsig_dev_st_t n;
  logic samp;
  logic dbit;
  logic [7:0] sel;
  logic ct_on;
  logic [31:0] ct_prod;
  logic [15:0] target;
  logic [15:0] delta;
  logic [15:0] ph_out;
  logic dcs_act;
  logic [4:0] dcs_last;
  logic [4:0] tx_idx;
  logic tx_ok;
  logic [31:0] tone_prod;
  logic [11:0] diff;
  logic rep;
  logic [4:0] rep_code;

  // bus ports come straight from state flops
  assign bus.rdata = r.rdata;
  assign bus.rvalid = r.rvalid;
  assign bus.irq = r.irq;
  assign sub_phase = r.sub_phase;
  assign sub_on = r.sub_on;
  assign dcs_bit = r.dcs_bit;
  assign dcs_on = r.dcs_on;
  assign tone_sq = r.tone_sq;
  assign tone_on = r.tone_on;
  assign tone_level = r.tone_level;

  // next-state logic; status sets come after the read-clear so a set wins
  always_comb begin
    n = r;
    n.rvalid = 1'b0;
    samp = (r.smp_cnt == 14'(SAMPLE_CYC - 1));
    n.smp_cnt = samp ? 14'h0000 : r.smp_cnt + 14'h0001;
    dbit = (r.bit_cnt == 20'(DCS_BIT_CYC - 1));
    n.bit_cnt = dbit ? 20'h00000 : r.bit_cnt + 20'h00001;
    sel = r.audio[7:0];
    rep = 1'b0;
    rep_code = CODE_NONE;
    diff = 12'h000;
    // register writes
    if (bus.wr) begin
      case (bus.addr)
        ADDR_MODE: n.mode = bus.wdata;
        ADDR_AUDIO: n.audio = bus.wdata;
        ADDR_TXTONE: n.txtone = bus.wdata;
        ADDR_PROG: begin
          if (bus.loc == LOC_TONE_LEVEL_SETTING) begin
            n.level = bus.wdata[11:0];
          end else if (bus.loc >= LOC_SELCALL_FIRST && bus.loc <= LOC_SELCALL_LAST) begin
            n.tbl[5'(bus.loc + 6'h02)] = bus.wdata[11:0];
          end else if (bus.loc >= LOC_CUSTOM_TONE_ONE_FREQ && bus.loc <= LOC_CUSTOM_LAST) begin
            n.tbl[5'(bus.loc - LOC_CUSTOM_TONE_ONE_FREQ)] = bus.wdata[11:0];
          end else if (bus.loc == LOC_SQUELCH_CODE_CONFIG_WORD) begin
            n.dcs24 = bus.wdata[SQ_LEN24_BIT];
          end else if (bus.loc == LOC_DCS_LO) begin
            n.dcs_word[11:0] = bus.wdata[11:0];
          end else if (bus.loc == LOC_DCS_HI) begin
            n.dcs_word[23:12] = bus.wdata[11:0];
          end
        end
        default: ;
      endcase
    end
    // register reads answer one cycle later; status read clears it
    if (bus.rd) begin
      n.rvalid = 1'b1;
      case (bus.addr)
        ADDR_MODE: n.rdata = r.mode;
        ADDR_AUDIO: n.rdata = r.audio;
        ADDR_TXTONE: n.rdata = r.txtone;
        ADDR_TSTAT: n.rdata = r.tstat;
        ADDR_IRQST: begin
          n.rdata = r.irqst;
          n.irqst = 16'h0000;
        end
        default: n.rdata = 16'h0000;
      endcase
    end
    // sub-audio tone: index scales a frequency step
    ct_on = r.mode[MODE_CTCSS_BIT] && sel != 8'h00 && sel != SEL_TURNOFF;
    ct_prod = (32'(sel) * 32'(CT_STEP_DHZ) + 32'(CT_BASE_DHZ)) * 32'(PH_MUL_DHZ);
    case (r.audio[AUD_PH_LSB +: 2])
      2'b01: target = PH_120;
      2'b10: target = PH_180;
      2'b11: target = PH_240;
      default: target = 16'h0000;
    endcase
    delta = target - r.shift;
    ph_out = r.sub_acc - r.shift;
    // phase only ever moves backwards in small steps to avoid spurious splatter
    if (samp) begin
      n.shift = r.shift + ((delta > PH_STEP) ? PH_STEP : delta);
      n.sub_acc = ct_on ? r.sub_acc + ct_prod[25:10] : 16'h0000;
      n.sub_phase = ph_out[15:8];
      n.sub_on = ct_on;
    end
    // squelch word serialiser, user word only; table codes are not stored
    dcs_act = r.mode[MODE_DCS_BIT] &&
      (sel == SEL_USER || sel == SEL_USER_INV || sel == SEL_TURNOFF);
    dcs_last = r.dcs24 ? 5'(DCS_LEN24 - 1) : 5'(DCS_LEN23 - 1);
    if (!dcs_act) begin
      n.dcs_on = 1'b0;
      n.dcs_bit = 1'b0;
      n.dcs_pos = 5'h00;
    end else if (dbit) begin
      n.dcs_on = 1'b1;
      if (sel == SEL_TURNOFF) begin
        n.dcs_bit = ~r.dcs_bit;
      end else begin
        n.dcs_bit = r.dcs_word[r.dcs_pos] ^ (sel == SEL_USER_INV);
        n.dcs_pos = (r.dcs_pos == dcs_last) ? 5'h00 : r.dcs_pos + 5'h01;
      end
    end
    // inband tone generator
    tx_ok = r.txtone[TC_GROUP_BIT] || (r.txtone[14:11] >= 4'h1 && r.txtone[14:11] <= 4'h4);
    tx_idx = r.txtone[TC_GROUP_BIT] ? 5'(r.txtone[14:11]) + 5'h04 :
      5'(r.txtone[14:11] - 4'h1);
    tone_prod = 32'(r.tbl[tx_idx]) * 32'(PH_MUL_HZ);
    if (samp) begin
      if (r.mode[MODE_INB_LSB +: 3] == INB_TX && tx_ok) begin
        n.tone_acc = r.tone_acc + tone_prod[25:10];
        n.tone_on = 1'b1;
      end else begin
        n.tone_acc = 16'h0000;
        n.tone_on = 1'b0;
      end
      n.tone_sq = r.tone_acc[15];
      n.tone_level = r.level;
    end
    // receive scan: one table entry a cycle, custom tones first
    case (r.sc)
      SC_IDLE: begin
        if (det_strobe && r.mode[MODE_INB_LSB +: 3] == INB_RX) begin
          if (!det_on) begin
            rep = 1'b1;
          end else begin
            n.freq = det_freq;
            n.scan = 5'h00;
            n.sc = SC_RUN;
          end
        end
      end
      SC_RUN: begin
        diff = (r.tbl[r.scan] > r.freq) ? r.tbl[r.scan] - r.freq : r.freq - r.tbl[r.scan];
        if (diff <= MATCH_TOL_HZ) begin
          rep = 1'b1;
          rep_code = (r.scan < 5'h04) ? r.scan + 5'h01 : {1'b1, 4'(r.scan - 5'h04)};
          n.sc = SC_IDLE;
        end else if (r.scan == 5'h13) begin
          rep = 1'b1;
          rep_code = CODE_UNREC;
          n.sc = SC_IDLE;
        end else begin
          n.scan = r.scan + 5'h01;
        end
      end
      default: n.sc = SC_IDLE;
    endcase
    // only a change of state of the detected tone raises the event
    if (rep && (rep_code != r.tstat[15:11] || r.tstat[TS_DUAL_BIT])) begin
      n.tstat = {rep_code, 11'h000};
      n.irqst[IRQ_INB_BIT] = 1'b1;
    end
    // dual tone result overrides any inband value
    if (dual_strobe && r.mode[MODE_DUAL_BIT]) begin
      n.tstat = {5'h00, 1'b1, 6'h00, dual_code};
      n.irqst[IRQ_DUAL_BIT] = 1'b1;
    end
    n.irq = n.mode[MODE_IRQEN_BIT] && (n.irqst != 16'h0000);
  end

  // state register; tone table comes up holding the default set
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.tbl <= {EEA_TONES, 48'h000000000000};
      r.sc <= SC_IDLE;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// >>> sitsig_host.sv
`default_nettype none
module sitsig_host
  import sitsig_pkg::*;
#(
  parameter int DCS_OFF_CYC = DCS_OFF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // user command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [5:0] cmd_loc,
  input wire logic [15:0] cmd_wdata,
  input wire logic dcs_stop,
  input wire logic want_24bit,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic refused,
  output logic irq,
  // register port toward the device
  sitsig_if.host bus
);
  typedef struct packed {
    sitsig_hst_t st;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [5:0] loc;
    logic [15:0] wdata;
    logic [7:0] a2;
    logic [5:0] l2;
    logic [15:0] d2;
    logic [15:0] mode;
    logic [15:0] audio;
    logic [4:0] last_tone;
    logic tx_flag;
    logic [24:0] cnt;
    logic ready;
    logic resp_valid;
    logic [15:0] resp_data;
    logic refused;
    logic irq;
  } sitsig_host_st_t;

  sitsig_host_st_t r;
  sitsig_host_st_t n;
  logic take;
  logic [4:0] code;
  logic [11:0] f;

  assign bus.wr = r.wr;
  assign bus.rd = r.rd;
  assign bus.addr = r.addr;
  assign bus.loc = r.loc;
  assign bus.wdata = r.wdata;
  assign cmd_ready = r.ready;
  assign resp_valid = r.resp_valid;
  assign resp_data = r.resp_data;
  assign refused = r.refused;
  assign irq = r.irq;

  // command sequencer; some commands expand into two device writes
  always_comb begin
    n = r;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.resp_valid = 1'b0;
    n.refused = 1'b0;
    n.irq = bus.irq;
    take = cmd_valid && r.ready;
    code = cmd_wdata[15:11];
    f = cmd_wdata[11:0];
    case (r.st)
      H_IDLE: begin
        n.ready = 1'b1;
        if (r.ready && dcs_stop) begin
          n.ready = 1'b0;
          n.audio = {r.audio[15:8], SEL_TURNOFF};
          n.wr = 1'b1;
          n.addr = ADDR_AUDIO;
          n.wdata = n.audio;
          n.cnt = 25'h0000000;
          n.st = H_HOLD;
        end else if (take && !cmd_write) begin
          n.ready = 1'b0;
          n.rd = 1'b1;
          n.addr = cmd_addr;
          n.st = H_READ;
        end else if (take) begin
          n.ready = 1'b0;
          n.wr = 1'b1;
          n.addr = cmd_addr;
          n.loc = cmd_loc;
          n.wdata = cmd_wdata;
          case (cmd_addr)
            ADDR_MODE: begin
              n.mode = cmd_wdata;
              // leaving tone transmit gives the paths back
              if (cmd_wdata[MODE_INB_LSB +: 3] != INB_TX) n.tx_flag = 1'b0;
              n.wdata = n.tx_flag ? cmd_wdata & ~PATH_MASK : cmd_wdata;
            end
            ADDR_AUDIO: n.audio = cmd_wdata;
            ADDR_TXTONE: begin
              if (code[4] && code == r.last_tone) code = {1'b1, CODE_REPEAT};
              n.last_tone = code;
              n.tx_flag = 1'b1;
              n.wdata = r.mode & ~PATH_MASK;
              n.addr = ADDR_MODE;
              n.a2 = ADDR_TXTONE;
              n.d2 = {code, cmd_wdata[10:0]};
              n.st = H_W2;
            end
            ADDR_PROG: begin
              if (cmd_loc == LOC_SQUELCH_CODE_CONFIG_WORD && want_24bit) begin
                n.wdata[SQ_LEN24_BIT] = 1'b1;
              end
              if (cmd_loc >= LOC_CUSTOM_TONE_ONE_FREQ && cmd_loc <= LOC_CUSTOM_LAST) begin
                if (f < INB_MIN_HZ || f > INB_MAX_HZ) begin
                  n.wr = 1'b0;
                  n.refused = 1'b1;
                end else if (f < INB_LOW_HZ) begin
                  n.mode = r.mode & ~SUB_MASK;
                  n.a2 = ADDR_MODE;
                  n.l2 = cmd_loc;
                  n.d2 = n.mode;
                  n.st = H_W2;
                end
              end
            end
            default: ;
          endcase
        end
      end
      H_W2: begin
        n.wr = 1'b1;
        n.addr = r.a2;
        n.loc = r.l2;
        n.wdata = r.d2;
        n.st = H_IDLE;
      end
      H_READ: begin
        if (bus.rvalid) begin
          n.resp_valid = 1'b1;
          n.resp_data = bus.rdata;
          n.st = H_IDLE;
        end
      end
      H_HOLD: begin
        // turn-off value stands before coding is switched off
        n.cnt = r.cnt + 25'h0000001;
        if (r.cnt == 25'(DCS_OFF_CYC - 1)) begin
          n.mode = r.mode & ~16'h0002;
          n.wr = 1'b1;
          n.addr = ADDR_MODE;
          n.wdata = r.tx_flag ? n.mode & ~PATH_MASK : n.mode;
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= H_IDLE;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// >>> sitsig_asserts.sv
`default_nettype none
module sitsig_asserts
  import sitsig_pkg::*;
#(
  parameter int OFF_CYC = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port between the two ends
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [5:0] loc,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] mode_reg;
  logic [15:0] mode_next;
  logic cust_wr;
  // shadow of the last mode word, so outputs can be tied to their enables
  always_comb begin
    mode_next = (wr && addr == ADDR_MODE) ? wdata : mode_reg;
    cust_wr = wr && addr == ADDR_PROG && loc >= LOC_CUSTOM_TONE_ONE_FREQ
      && loc <= LOC_CUSTOM_LAST;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= 16'h0000;
    end else begin
      mode_reg <= mode_next;
    end
  end
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read strobe not answered in the next cycle");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("read answer without a read strobe");
  a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved outside a read answer");
  a_strobe_excl: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_turnoff_hold: assert property (
    (wr && addr == ADDR_AUDIO && wdata[7:0] == SEL_TURNOFF)
    |-> ##OFF_CYC (wr && addr == ADDR_MODE && !wdata[MODE_DCS_BIT]))
    else $error("turn-off code not held for the set time");
  a_mute_first: assert property ((wr && addr == ADDR_TXTONE)
    |-> $past(wr) && (mode_reg & PATH_MASK) == 16'h0000)
    else $error("tone sent with audio or data path open");
  a_tone_range: assert property (cust_wr
    |-> wdata[11:0] >= INB_MIN_HZ && wdata[11:0] <= INB_MAX_HZ)
    else $error("custom tone written outside the inband range");
  a_low_tone: assert property ((cust_wr && wdata[11:0] < INB_LOW_HZ)
    |=> wr && addr == ADDR_MODE && (wdata & SUB_MASK) == 16'h0000)
    else $error("low tone without sub-audio and filter off");
  // irq is registered from the mode word of the same edge that updates the shadow
  a_irq_enable: assert property ($rose(irq) |-> mode_reg[MODE_IRQEN_BIT])
    else $error("interrupt raised while disabled");
  c_tone_tx: cover property (wr && addr == ADDR_TXTONE);
  c_inb_event: cover property (rvalid && rdata[IRQ_INB_BIT]);
  c_turnoff: cover property (wr && addr == ADDR_AUDIO && wdata[7:0] == SEL_TURNOFF);
endmodule
`default_nettype wire

// >>> sitsig_bench.sv
`default_nettype none
module sitsig_bench
  import sitsig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 16;
  localparam int OFF = 20;
  localparam logic [23:0] WORD = 24'hD3A16C;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, dcs_stop = 1'b0, want_24bit = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [5:0] cmd_loc = 6'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic det_strobe = 1'b0, det_on = 1'b0, dual_strobe = 1'b0;
  logic [11:0] det_freq = 12'h000;
  logic [3:0] dual_code = 4'h0;
  logic cmd_ready, resp_valid, refused, irq, sub_on, dcs_bit, dcs_on, tone_sq, tone_on;
  logic ref_seen;
  logic [15:0] resp_data, last_tone;
  logic [7:0] sub_phase;
  logic [11:0] tone_level;
  int error_cnt = 0;
  int checks_done = 0;
  sitsig_if i_sitsig_if ();
  // free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // short counts keep the run brief; expectations use the same figures
  sitsig_dev #(.SAMPLE_CYC(8), .DCS_BIT_CYC(BIT_CYC)) i_sitsig_dev (.sys_clk(sys_clk),
    .arst_n(arst_n), .bus(i_sitsig_if.dev), .det_strobe(det_strobe), .det_on(det_on),
    .det_freq(det_freq), .dual_strobe(dual_strobe), .dual_code(dual_code),
    .sub_phase(sub_phase), .sub_on(sub_on), .dcs_bit(dcs_bit), .dcs_on(dcs_on),
    .tone_sq(tone_sq), .tone_on(tone_on), .tone_level(tone_level));
  sitsig_host #(.DCS_OFF_CYC(OFF)) i_sitsig_host (.sys_clk(sys_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_loc(cmd_loc),
    .cmd_wdata(cmd_wdata), .dcs_stop(dcs_stop), .want_24bit(want_24bit),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .refused(refused), .irq(irq), .bus(i_sitsig_if.host));
  sitsig_asserts #(.OFF_CYC(OFF)) i_sitsig_asserts (.sys_clk(sys_clk), .arst_n(arst_n),
    .wr(i_sitsig_if.wr), .rd(i_sitsig_if.rd), .addr(i_sitsig_if.addr),
    .loc(i_sitsig_if.loc), .wdata(i_sitsig_if.wdata), .rdata(i_sitsig_if.rdata),
    .rvalid(i_sitsig_if.rvalid), .irq(i_sitsig_if.irq));
  // last tone word seen on the wire, to see what the host really sent
  always @(posedge sys_clk) begin
    if (i_sitsig_if.wr && i_sitsig_if.addr == ADDR_TXTONE) last_tone <= i_sitsig_if.wdata;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one host command; a read waits for its answer, a write samples refusal
  task automatic cmd(input logic w, input logic [7:0] a, input logic [5:0] l,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    q = 16'hXXXX;
    while (cmd_ready !== 1'b1 && n < 100) begin
      cycles(1);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_loc = l;
    cmd_wdata = d;
    cycles(1);
    cmd_valid = 1'b0;
    ref_seen = refused;
    n = 0;
    while (!w && resp_valid !== 1'b1 && n < 10) begin
      cycles(1);
      n++;
    end
    if (w) cycles(1);
    // a read that never got its answer hands back unknown, so the compare fails
    q = (w || resp_valid === 1'b1) ? resp_data : 16'hXXXX;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [5:0] l, input logic [15:0] d);
    logic [15:0] q;
    cmd(1'b1, a, l, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    cmd(1'b0, a, 6'h00, 16'h0000, q);
    check(q, exp);
  endtask
  // sub-audio tone runs, then each phase step retards by its share within 170 samples
  task automatic t_subaudio();
    logic [7:0] tgt[4] = '{8'h00, 8'h55, 8'h80, 8'hAB};
    logic [7:0] p0, s0, d;
    wreg(ADDR_MODE, 6'h00, 16'h0001);
    wreg(ADDR_AUDIO, 6'h00, 16'h0005);
    cycles(8);
    check({15'h0000, sub_on}, 16'h0001);
    p0 = sub_phase;
    cycles(1360);
    s0 = sub_phase - p0;
    check({15'h0000, s0 != 8'h00}, 16'h0001);
    for (int k = 1; k < 4; k++) begin
      wreg(ADDR_AUDIO, 6'h00, {6'h00, 2'(k), 8'h05});
      p0 = sub_phase;
      cycles(1360);
      d = s0 - (sub_phase - p0) - (tgt[k] - tgt[k - 1]);
      check({15'h0000, d <= 8'h03 || d >= 8'hFD}, 16'h0001);
    end
  endtask
  // squelch word: find its rotation in 48 mid-bit samples at the bit rate
  task automatic t_squelch(input logic [7:0] sel, input logic w24, input logic [15:0] cfg,
    input int len);
    logic [47:0] got;
    logic b, ok, hit, inv;
    int k;
    inv = (sel == SEL_USER_INV);
    want_24bit = w24;
    wreg(ADDR_PROG, LOC_SQUELCH_CODE_CONFIG_WORD, cfg);
    wreg(ADDR_PROG, LOC_DCS_LO, {4'h0, WORD[11:0]});
    wreg(ADDR_PROG, LOC_DCS_HI, {4'h0, WORD[23:12]});
    wreg(ADDR_MODE, 6'h00, 16'h0002);
    wreg(ADDR_AUDIO, 6'h00, {8'h00, sel});
    b = dcs_bit;
    k = 0;
    while (dcs_bit === b && k < 64) begin
      cycles(1);
      k++;
    end
    cycles(BIT_CYC / 2);
    for (k = 0; k < 48; k++) begin
      got[k] = dcs_bit;
      cycles(BIT_CYC);
    end
    hit = 1'b0;
    for (int r = 0; r < len; r++) begin
      ok = 1'b1;
      for (k = 0; k < 48; k++) if (got[k] !== (WORD[(r + k) % len] ^ inv)) ok = 1'b0;
      if (ok) hit = 1'b1;
    end
    check({15'h0000, hit}, 16'h0001);
  endtask
  // one detector result, then irq, tone status and irq status are judged
  task automatic detect(input logic dual, input logic on, input logic [11:0] f,
    input logic [15:0] ts, input logic [15:0] is);
    int k;
    det_on = on;
    det_freq = f;
    dual_code = 4'h5;
    det_strobe = !dual;
    dual_strobe = dual;
    cycles(1);
    det_strobe = 1'b0;
    dual_strobe = 1'b0;
    k = 0;
    while (irq !== 1'b1 && k < 30) begin
      cycles(1);
      k++;
    end
    check({15'h0000, irq}, 16'h0001);
    rchk(ADDR_TSTAT, ts);
    rchk(ADDR_IRQST, is);
    cycles(2);
    check({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_receive();
    wreg(ADDR_MODE, 6'h00, 16'h8200);
    detect(1'b0, 1'b1, EEA_TONES[3] + 12'h003, 16'h9800, 16'h2000);
    detect(1'b0, 1'b1, 12'hB54, 16'h7800, 16'h2000);
    detect(1'b0, 1'b0, 12'hB54, 16'h0000, 16'h2000);
    wreg(ADDR_PROG, LOC_CUSTOM_TONE_ONE_FREQ, {4'h0, EEA_TONES[3]});
    detect(1'b0, 1'b1, EEA_TONES[3], 16'h0800, 16'h2000);
    wreg(ADDR_PROG, 6'h13, 16'h015E);
    detect(1'b0, 1'b1, 12'h15E, 16'h1000, 16'h2000);
    wreg(ADDR_PROG, 6'h14, 16'h0FA0);
    check({15'h0000, ref_seen}, 16'h0001);
    wreg(ADDR_MODE, 6'h00, 16'h9200);
    detect(1'b1, 1'b1, 12'h15E, 16'h0405, 16'h1000);
    wreg(ADDR_MODE, 6'h00, 16'h0200);
    det_on = 1'b0;
    det_strobe = 1'b1;
    cycles(1);
    det_strobe = 1'b0;
    cycles(30);
    check({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_transmit();
    logic b;
    int n;
    wreg(ADDR_PROG, LOC_TONE_LEVEL_SETTING, 16'h0123);
    wreg(ADDR_MODE, 6'h00, 16'h0430);
    wreg(ADDR_TXTONE, 6'h00, 16'h9800);
    cycles(20);
    check({15'h0000, tone_on}, 16'h0001);
    check({4'h0, tone_level}, 16'h0123);
    // 1275 Hz over 25 samples of 8 kHz is about four periods, so 7 or 8 toggles
    n = 0;
    b = tone_sq;
    for (int k = 0; k < 200; k++) begin
      cycles(1);
      if (tone_sq !== b) n++;
      b = tone_sq;
    end
    check({15'h0000, n >= 7 && n <= 8}, 16'h0001);
    check(last_tone, 16'h9800);
    wreg(ADDR_TXTONE, 6'h00, 16'h9800);
    cycles(4);
    check(last_tone, 16'hF000);
  endtask
  task automatic results();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole run needs about 8.5k cycles
  initial begin
    #500_000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    cycles(2);
    rchk(ADDR_TSTAT, 16'h0000);
    t_subaudio();
    t_squelch(SEL_USER, 1'b0, 16'h0000, 23);
    t_squelch(SEL_USER_INV, 1'b0, 16'h0800, 24);
    t_squelch(SEL_USER, 1'b1, 16'h0000, 24);
    while (cmd_ready !== 1'b1) cycles(1);
    dcs_stop = 1'b1;
    cycles(1);
    dcs_stop = 1'b0;
    cycles(OFF / 2);
    check({15'h0000, dcs_on}, 16'h0001);
    cycles(OFF);
    check({15'h0000, dcs_on}, 16'h0000);
    t_receive();
    t_transmit();
    results();
  end
endmodule
`default_nettype wire
